// file: rtl/rptc_pkg.sv
// package: register map, field layout, timing and types of the relay totalizer controller
package rptc_pkg;
  // timing: one-second tick from the 200 MHz system clock
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC_DEF = TICK_S * CLK_HZ;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam int unsigned N_DIN = 2;

  // register map: relay i occupies a block at i * 0x10 (address bits 7:4 select the relay)
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_AMT = 4'h4;
  localparam logic [3:0] OFS_OFFD = 4'h8;
  localparam logic [3:0] OFS_SETPT = 4'hc;
  localparam logic [7:0] REG_ALARM = 8'h40;
  localparam logic [7:0] REG_DICFG = 8'h44;
  localparam logic [7:0] REG_OVR = 8'h48;
  localparam logic [7:0] REG_STAT = 8'h4c;
  localparam logic [7:0] REG_MODE = 8'h50;

  // relay config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_POL = 8;
  localparam int CFG_FEN = 9;
  localparam int CFG_FVAL = 10;
  localparam int CFG_FSEN = 11;
  localparam int CFG_FSVAL = 12;
  localparam int CFG_PAUSE = 13;
  localparam int AMT_LSB = 0;
  localparam int INTV_LSB = 16;
  localparam int HI_LSB = 16;
  localparam int MODE_FLD_W = 4;

  // discrete input config fields, one byte per input
  localparam int DI_W = 8;
  localparam int DI_POL = 3;
  localparam int DI_SIM_EN = 4;
  localparam int DI_SIM_VAL = 5;

  // status register fields
  localparam int STAT_DI_LSB = 8;
  localparam int STAT_HI = 10;
  localparam int STAT_LO = 11;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_ALARM, MODE_SETPT, MODE_TOTAL, MODE_SAMPLE, MODE_ELAPSED, MODE_APP
  } rptc_mode_t;
  typedef enum logic [1:0] {SRC_LEVEL, SRC_FLOW, SRC_PUMP} rptc_src_t;
  typedef enum logic [1:0] {PH_IDLE, PH_HI, PH_LO} rptc_ph_t;
  typedef enum logic [2:0] {
    DF_NONE, DF_TRESET, DF_TPAUSE, DF_FORCE, DF_FREEZE, DF_ACK, DF_OVR
  } rptc_dfn_t;

  typedef struct packed {
    rptc_mode_t mode;
    rptc_src_t src;
    logic pol_low;
    logic fen;
    logic fval;
    logic fsen;
    logic fsval;
    logic pause;
    logic [15:0] amt;
    logic [7:0] intv;
    logic [15:0] offd;
    logic [15:0] sp_on;
    logic [15:0] sp_off;
    logic [19:0] acc;
    logic [7:0] pend;
    rptc_ph_t ph;
    logic [15:0] tcnt;
    logic [23:0] icnt;
    logic sp_st;
    logic coil;
  } rptc_rly_t;
endpackage

// file: rtl/rptc_top.sv
// relay pulse totalizer control: relays, timers, discrete inputs, register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rptc_top import rptc_pkg::*; #(
  parameter int N_RELAY = 2,
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic [15:0] level_in,
  input wire logic level_bad_in,
  input wire logic [15:0] flow_vol_in,
  input wire logic flow_vld_in,
  input wire logic flow_bad_in,
  input wire logic [15:0] pump_vol_in,
  input wire logic pump_done_in,
  input wire logic pump_bad_in,
  input wire logic [N_RELAY-1:0] app_claim_in,
  input wire logic [N_RELAY-1:0] app_req_in,
  input wire logic [N_DIN-1:0] discrete_input_line_in,
  output logic [N_DIN-1:0] din_state_out,
  output logic [N_RELAY-1:0] relay_coil_out,
  output logic [15:0] level_out,
  output logic diag_ack_out
);
  typedef struct packed {
    rptc_rly_t [N_RELAY-1:0] rly;
    logic [N_DIN-1:0] s1;
    logic [N_DIN-1:0] s2;
    logic [N_DIN-1:0] s3;
    logic [N_DIN-1:0] stab;
    logic [N_DIN-1:0] act;
    logic [N_DIN*DI_W-1:0] dicfg;
    logic [15:0] up;
    logic [15:0] lo;
    logic [15:0] ovr;
    logic [15:0] lvl;
    logic ack;
    logic [31:0] tcyc;
    logic [31:0] rd;
  } rptc_st_t;

  rptc_st_t r;
  rptc_st_t n;
  logic tick;
  logic hi;
  logic lo;
  logic [7:0] fn_on;
  logic [N_RELAY-1:0] bad_v;
  logic [N_RELAY-1:0] hold_v;
  logic [N_RELAY-1:0] unit_v;
  logic [N_RELAY-1:0] exp_v;
  logic [N_RELAY-1:0] f_v;

  // whole next state; register writes are applied last so they win
  always_comb begin
    rptc_rly_t q;
    logic [DI_W-1:0] c;
    logic fire;
    logic coil;
    logic [23:0] lim;
    logic [31:0] v;
    rptc_mode_t me;
    q = '0;
    c = '0;
    fire = 1'b0;
    coil = 1'b0;
    lim = '0;
    v = '0;
    me = MODE_OFF;
    n = r;
    fn_on = '0;
    bad_v = '0;
    hold_v = '0;
    unit_v = '0;
    exp_v = '0;
    f_v = '0;
    n.ack = 1'b0;
    n.rd = '0;
    // free-running one-second tick
    tick = (r.tcyc == TICK_CYC - 1);
    n.tcyc = tick ? '0 : r.tcyc + 32'h1;

    // pin synchroniser: a level change counts once stages two and three agree
    n.s1 = discrete_input_line_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int d = 0; d < N_DIN; d++) begin
      c = r.dicfg[d*DI_W +: DI_W];
      if (r.s2[d] == r.s3[d]) n.stab[d] = r.s3[d];
      n.act[d] = (c[DI_SIM_EN] ? c[DI_SIM_VAL] : r.stab[d]) ^ c[DI_POL];
      // a function of none leaves the input without effect
      if (n.act[d]) fn_on[c[2:0]] = 1'b1;
      if (n.act[d] && !r.act[d] && c[2:0] == DF_ACK) n.ack = 1'b1;
    end

    // level path: override beats freeze, both act on every consumer of level
    if (fn_on[DF_OVR]) n.lvl = r.ovr;
    else if (!fn_on[DF_FREEZE]) n.lvl = level_in;
    hi = (r.lvl >= r.up);
    lo = (r.lvl <= r.lo);

    for (int i = 0; i < N_RELAY; i++) begin
      q = r.rly[i];
      fire = 1'b0;
      me = app_claim_in[i] ? MODE_APP : q.mode;
      case (q.src)
        SRC_FLOW: bad_v[i] = flow_bad_in;
        SRC_PUMP: bad_v[i] = pump_bad_in;
        default: bad_v[i] = level_bad_in;
      endcase
      hold_v[i] = (q.pause && bad_v[i]) || fn_on[DF_TPAUSE];
      // one unit per cycle; far faster than any contact so nothing backs up
      unit_v[i] = (q.mode == MODE_TOTAL || q.mode == MODE_SAMPLE) && q.amt != '0
                  && q.acc >= 20'(q.amt);
      if (unit_v[i]) begin
        q.acc = q.acc - 20'(q.amt);
        fire = 1'b1;
      end
      if (!hold_v[i]) begin
        if (q.src == SRC_FLOW && flow_vld_in) q.acc = q.acc + 20'(flow_vol_in);
        if (q.src == SRC_PUMP && pump_done_in) q.acc = q.acc + 20'(pump_vol_in);
      end
      // interval in hours counted as seconds of the tick
      lim = 24'(32'(q.intv) * SEC_PER_HOUR);
      exp_v[i] = tick && q.intv != '0 && (q.icnt + 24'h1 >= lim);
      if (tick) q.icnt = q.icnt + 24'h1;
      if (q.mode == MODE_SAMPLE || q.mode == MODE_ELAPSED) begin
        if (exp_v[i]) fire = 1'b1;
      end
      if (fire || exp_v[i]) q.icnt = '0;
      if (fn_on[DF_TRESET]) begin
        q.acc = '0;
        q.pend = '0;
        fire = 1'b0;
      end
      if (fire && q.pend != 8'hff) q.pend = q.pend + 8'h1;

      // contact engine: high for off-delay, then low for off-delay
      case (q.ph)
        PH_IDLE: begin
          if (q.pend != '0) begin
            q.ph = PH_HI;
            q.tcnt = q.offd;
            q.pend = q.pend - 8'h1;
          end
        end
        PH_HI: begin
          if (tick) begin
            if (q.tcnt <= 16'h1) begin
              q.ph = PH_LO;
              q.tcnt = q.offd;
            end else begin
              q.tcnt = q.tcnt - 16'h1;
            end
          end
        end
        PH_LO: begin
          if (tick) begin
            if (q.tcnt > 16'h1) begin
              q.tcnt = q.tcnt - 16'h1;
            end else if (q.pend != '0) begin
              // a queued contact starts on this tick; an idle cycle would stretch the low time
              q.ph = PH_HI;
              q.tcnt = q.offd;
              q.pend = q.pend - 8'h1;
            end else begin
              q.ph = PH_IDLE;
            end
          end
        end
        default: q.ph = PH_IDLE;
      endcase

      // setpoint latch; direction from the order of ON and OFF
      if (q.sp_on > q.sp_off) begin
        if (r.lvl >= q.sp_on) q.sp_st = 1'b1;
        else if (r.lvl <= q.sp_off) q.sp_st = 1'b0;
      end else begin
        if (r.lvl <= q.sp_on) q.sp_st = 1'b1;
        else if (r.lvl >= q.sp_off) q.sp_st = 1'b0;
      end

      case (me)
        MODE_ALARM: f_v[i] = hi || lo;
        MODE_SETPT: f_v[i] = q.sp_st;
        MODE_TOTAL, MODE_SAMPLE, MODE_ELAPSED: f_v[i] = (q.ph == PH_HI);
        MODE_APP: f_v[i] = app_req_in[i];
        default: f_v[i] = 1'b0;
      endcase
      coil = q.pol_low ? !f_v[i] : f_v[i];
      if (q.fsen && bad_v[i]) coil = q.fsval;
      if (q.fen || fn_on[DF_FORCE]) coil = q.fval;
      q.coil = coil;

      // relay block writes
      if (wr_in && addr_in[7:4] == 4'(i)) begin
        case (addr_in[3:0])
          OFS_CFG: begin
            q.mode = rptc_mode_t'(wr_data_in[CFG_MODE_LSB +: 3]);
            q.src = rptc_src_t'(wr_data_in[CFG_SRC_LSB +: 2]);
            q.pol_low = wr_data_in[CFG_POL];
            q.fen = wr_data_in[CFG_FEN];
            q.fval = wr_data_in[CFG_FVAL];
            q.fsen = wr_data_in[CFG_FSEN];
            q.fsval = wr_data_in[CFG_FSVAL];
            q.pause = wr_data_in[CFG_PAUSE];
          end
          OFS_AMT: begin
            q.amt = wr_data_in[AMT_LSB +: 16];
            q.intv = wr_data_in[INTV_LSB +: 8];
          end
          OFS_OFFD: q.offd = wr_data_in[15:0];
          OFS_SETPT: begin
            q.sp_on = wr_data_in[15:0];
            q.sp_off = wr_data_in[HI_LSB +: 16];
          end
          default: ;
        endcase
      end
      n.rly[i] = q;

      // relay block reads answer from the registered state
      if (rd_in && addr_in[7:4] == 4'(i)) begin
        v = '0;
        case (addr_in[3:0])
          OFS_CFG: begin
            v[CFG_MODE_LSB +: 3] = r.rly[i].mode;
            v[CFG_SRC_LSB +: 2] = r.rly[i].src;
            v[CFG_POL] = r.rly[i].pol_low;
            v[CFG_FEN] = r.rly[i].fen;
            v[CFG_FVAL] = r.rly[i].fval;
            v[CFG_FSEN] = r.rly[i].fsen;
            v[CFG_FSVAL] = r.rly[i].fsval;
            v[CFG_PAUSE] = r.rly[i].pause;
          end
          OFS_AMT: begin
            v[AMT_LSB +: 16] = r.rly[i].amt;
            v[INTV_LSB +: 8] = r.rly[i].intv;
          end
          OFS_OFFD: v[15:0] = r.rly[i].offd;
          OFS_SETPT: v = {r.rly[i].sp_off, r.rly[i].sp_on};
          default: ;
        endcase
        n.rd = v;
      end
      if (rd_in && addr_in == REG_MODE) n.rd[i*MODE_FLD_W +: 3] = me;
      if (rd_in && addr_in == REG_STAT) n.rd[i] = r.rly[i].coil;
    end

    // global registers
    if (wr_in) begin
      case (addr_in)
        REG_ALARM: {n.lo, n.up} = wr_data_in;
        REG_DICFG: n.dicfg = wr_data_in[N_DIN*DI_W-1:0];
        REG_OVR: n.ovr = wr_data_in[15:0];
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        REG_ALARM: n.rd = {r.lo, r.up};
        REG_DICFG: n.rd = 32'(r.dicfg);
        REG_OVR: n.rd = {16'h0, r.ovr};
        REG_STAT: begin
          n.rd[STAT_DI_LSB +: N_DIN] = r.act;
          n.rd[STAT_HI] = hi;
          n.rd[STAT_LO] = lo;
        end
        default: ;
      endcase
    end
  end

  // single state register; clock enable low freezes everything but reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign rd_data_out = r.rd;
  assign level_out = r.lvl;
  assign diag_ack_out = r.ack;
  assign din_state_out = r.act;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_override_level: assert property (
    ce_in && fn_on[DF_OVR] |=> level_out == $past(r.ovr))
    else $error("override value not on level output");

  for (genvar g = 0; g < N_RELAY; g++) begin : g_rly
    assign relay_coil_out[g] = r.rly[g].coil;

    a_force_value: assert property (
      ce_in && r.rly[g].fen |=> relay_coil_out[g] == $past(r.rly[g].fval))
      else $error("forced relay not at forced value");

    a_failsafe_first: assert property (
      ce_in && r.rly[g].fsen && bad_v[g] && !r.rly[g].fen && !fn_on[DF_FORCE]
      |=> relay_coil_out[g] == $past(r.rly[g].fsval))
      else $error("fail-safe state not taken");

    a_polarity_invert: assert property (
      ce_in && !r.rly[g].fen && !fn_on[DF_FORCE] && !(r.rly[g].fsen && bad_v[g])
      |=> relay_coil_out[g] == ($past(f_v[g]) ^ $past(r.rly[g].pol_low)))
      else $error("coil does not follow function and polarity");

    a_pulse_low_phase: assert property (
      ce_in && !wr_in && tick && r.rly[g].ph == PH_HI && r.rly[g].tcnt <= 16'h1
      |=> r.rly[g].ph == PH_LO && r.rly[g].tcnt == $past(r.rly[g].offd))
      else $error("high phase did not hand over to low phase");

    a_unit_carry: assert property (
      ce_in && !wr_in && unit_v[g] && !fn_on[DF_TRESET] && !flow_vld_in && !pump_done_in
      |=> r.rly[g].acc == $past(r.rly[g].acc) - 20'($past(r.rly[g].amt)))
      else $error("remainder not carried");

    a_pause_hold: assert property (
      ce_in && !wr_in && hold_v[g] && !unit_v[g] && !fn_on[DF_TRESET]
      |=> $stable(r.rly[g].acc))
      else $error("accumulation during pause");

    a_elapsed_fire: assert property (
      ce_in && !wr_in && !fn_on[DF_TRESET] && r.rly[g].mode == MODE_ELAPSED && exp_v[g]
      && r.rly[g].ph == PH_IDLE && r.rly[g].pend == '0
      |=> r.rly[g].ph == PH_HI ##1 !exp_v[g])
      else $error("elapsed interval did not start contact");

    a_sample_either: assert property (
      ce_in && !wr_in && !fn_on[DF_TRESET] && r.rly[g].mode == MODE_SAMPLE
      && (exp_v[g] || unit_v[g]) && r.rly[g].ph == PH_IDLE && r.rly[g].pend == '0
      |=> r.rly[g].ph == PH_HI && r.rly[g].icnt == '0)
      else $error("sampler trigger lost");

    a_app_mode: assert property (
      ce_in && rd_in && addr_in == REG_MODE && app_claim_in[g]
      |=> rd_data_out[g*MODE_FLD_W +: 3] == MODE_APP)
      else $error("claimed relay not reported as application");

    c_total_pulse: cover property (r.rly[g].mode == MODE_TOTAL && r.rly[g].ph == PH_LO);
    c_sample_time: cover property (r.rly[g].mode == MODE_SAMPLE && exp_v[g]);
    c_failsafe: cover property (r.rly[g].fsen && bad_v[g]);
  end
endmodule
`default_nettype wire

// file: verif/rptc_counter_model.sv
// external totalizer counter model: counts contact closures and measures contact times
`timescale 1ns/1ps
`default_nettype none
module rptc_counter_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic coil_in,
  output var int pulses_out,
  output var int hi_cyc_out,
  output var int lo_cyc_out
);
  int run_r;
  logic prev_r;

  // a counter only sees edges of the contact; run lengths give the closed and open times
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulses_out <= 0;
      hi_cyc_out <= 0;
      lo_cyc_out <= 0;
      run_r <= 0;
      prev_r <= 1'b0;
    end else begin
      prev_r <= coil_in;
      if (coil_in !== prev_r) begin
        run_r <= 1;
        if (prev_r === 1'b1) begin
          hi_cyc_out <= run_r;
        end else begin
          lo_cyc_out <= run_r;
        end
        if (coil_in === 1'b1) begin
          pulses_out <= pulses_out + 1;
        end
      end else begin
        run_r <= run_r + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/test_relay_pulse_totalizer_control.sv
// self-checking bench for the relay pulse totalizer controller
`timescale 1ns/1ps
`default_nettype none
module test_relay_pulse_totalizer_control import rptc_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0, rd = 1'b0, lbad = 1'b0, fvld = 1'b0, fbad = 1'b0, pdone = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [15:0] lvl = 16'h0, fvol = 16'h0, pvol = 16'h0;
  logic [1:0] claim = 2'h0, din = 2'h0, areq = 2'h0;
  wire logic [31:0] rdata;
  wire logic [1:0] dstate, coil;
  wire logic [15:0] lout;
  wire logic ack;
  int failures = 0, checked = 0, acks = 0, pulses, hi, lo, n, base;
  logic [31:0] cfgs [6] = '{32'h100, 32'h0, 32'h600, 32'h300, 32'h1800, 32'h0900};
  logic [5:0] bads = 6'h30, exps = 6'h15;
  logic [15:0] lvs [4] = '{16'h0050, 16'h0032, 16'h0014, 16'h0032};

  always #2.5 clk_sys_in = ~clk_sys_in;

  // short tick so that second and hour counts stay within a short run
  rptc_top #(.N_RELAY(2), .TICK_CYC(10)) u_rptc_top (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce), .addr_in(addr),
    .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
    .level_in(lvl), .level_bad_in(lbad), .flow_vol_in(fvol), .flow_vld_in(fvld),
    .flow_bad_in(fbad), .pump_vol_in(pvol), .pump_done_in(pdone), .pump_bad_in(1'b0),
    .app_claim_in(claim), .app_req_in(areq), .discrete_input_line_in(din),
    .din_state_out(dstate), .relay_coil_out(coil), .level_out(lout), .diag_ack_out(ack)
  );

  rptc_counter_model u_rptc_counter_model (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .coil_in(coil[0]),
    .pulses_out(pulses), .hi_cyc_out(hi), .lo_cyc_out(lo)
  );

  // acknowledge pulses last one cycle, so they are counted at every edge
  always @(posedge clk_sys_in) begin
    if (ack === 1'b1) acks <= acks + 1;
  end

  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t pin %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  task automatic do_reset;
    @(posedge clk_sys_in) rst_in <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so they are sampled there
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk_reg(rdata, e);
  endtask

  // one volume increment: flow sample or a finished pump cycle
  task automatic vol_in(input logic pump, input logic [15:0] v);
    @(posedge clk_sys_in);
    fvol <= v;
    pvol <= v;
    fvld <= ~pump;
    pdone <= pump;
    @(posedge clk_sys_in);
    fvld <= 1'b0;
    pdone <= 1'b0;
  endtask

  task automatic set_lvl(input logic [15:0] v, input logic e);
    @(posedge clk_sys_in) lvl <= v;
    cyc(4);
    #1 chk_out({15'h0, coil[0]}, {15'h0, e});
  endtask

  task automatic wait_coil(input logic v, input int lim);
    n = 0;
    while (coil[0] !== v && n < lim) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("MISMATCH %0t relay wait ran out", $time);
      report_and_stop;
    end
  endtask

  initial begin
    do_reset;
    rd_chk(8'h00, 32'h0);
    // limits and level both zero after reset, so both alarms stand
    rd_chk(REG_STAT, 32'h0000_0c00);
    wr_reg(8'h60, 32'hffff_ffff);
    rd_chk(8'h60, 32'h0);
    // totalizer on flow: amount 2, off-delay 2 s, remainder kept
    wr_reg(8'h04, 32'h2);
    wr_reg(8'h08, 32'h2);
    wr_reg(8'h00, 32'h13);
    repeat (5) vol_in(1'b0, 16'h0001);
    cyc(150);
    chk_reg(32'(pulses), 32'h2);
    chk_reg(32'(hi), 32'd20);
    chk_reg(32'(lo), 32'd20);
    vol_in(1'b0, 16'h0001);
    cyc(80);
    chk_reg(32'(pulses), 32'h3);
    // pumped volume: flow ignored, pulses only at cycle end
    do_reset;
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h00, 32'h23);
    repeat (3) vol_in(1'b0, 16'h0001);
    vol_in(1'b1, 16'h0004);
    cyc(60);
    chk_reg(32'(pulses), 32'h1);
    vol_in(1'b1, 16'h0002);
    cyc(60);
    chk_reg(32'(pulses), 32'h2);
    // pause counting while the flow value is faulty
    do_reset;
    wr_reg(8'h04, 32'h1);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h00, 32'h2013);
    @(posedge clk_sys_in) fbad <= 1'b1;
    repeat (2) vol_in(1'b0, 16'h0001);
    cyc(60);
    chk_reg(32'(pulses), 32'h0);
    @(posedge clk_sys_in) fbad <= 1'b0;
    vol_in(1'b0, 16'h0001);
    cyc(60);
    chk_reg(32'(pulses), 32'h1);
    // sampler closes on amount before its one-hour interval
    do_reset;
    wr_reg(8'h04, 32'h0001_0001);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h00, 32'h14);
    vol_in(1'b0, 16'h0001);
    cyc(60);
    chk_reg(32'(pulses), 32'h1);
    // polarity, forcing and fail-safe priority
    do_reset;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_in) lbad <= bads[i];
      wr_reg(8'h00, cfgs[i]);
      cyc(4);
      #1 chk_out({15'h0, coil[0]}, {15'h0, exps[i]});
    end
    @(posedge clk_sys_in) lbad <= 1'b0;
    // alarm limits: upper 100, lower 10
    wr_reg(REG_ALARM, 32'h000a_0064);
    wr_reg(8'h00, 32'h1);
    set_lvl(16'h0064, 1'b1);
    rd_chk(REG_STAT, 32'h0000_0401);
    set_lvl(16'h0032, 1'b0);
    set_lvl(16'h000a, 1'b1);
    rd_chk(REG_STAT, 32'h0000_0801);
    // pump down setpoints: on 80, off 20, hold between
    wr_reg(8'h0c, 32'h0014_0050);
    wr_reg(8'h00, 32'h2);
    for (int i = 0; i < 4; i++) set_lvl(lvs[i], i < 2);
    @(posedge clk_sys_in) claim <= 2'b10;
    areq <= 2'b10;
    wr_reg(8'h10, 32'h3);
    rd_chk(REG_MODE, 32'h0000_0062);
    chk_out({15'h0, coil[1]}, 16'h1);
    @(posedge clk_sys_in) claim <= 2'b00;
    areq <= 2'b00;
    // discrete inputs: override, acknowledge, freeze, force, polarity, simulation
    do_reset;
    wr_reg(REG_OVR, 32'h1234);
    wr_reg(REG_DICFG, 32'h0506);
    @(posedge clk_sys_in) lvl <= 16'h0077;
    din <= 2'b01;
    cyc(8);
    #1 chk_out(lout, 16'h1234);
    chk_out({14'h0, dstate}, 16'h1);
    @(posedge clk_sys_in) din <= 2'b00;
    cyc(8);
    #1 chk_out(lout, 16'h0077);
    base = acks;
    @(posedge clk_sys_in) din <= 2'b10;
    cyc(8);
    din <= 2'b00;
    cyc(8);
    chk_reg(32'(acks - base), 32'h1);
    wr_reg(8'h00, 32'h400);
    wr_reg(REG_DICFG, 32'h0304);
    @(posedge clk_sys_in) din <= 2'b11;
    cyc(8);
    lvl <= 16'h0099;
    cyc(4);
    #1 chk_out(lout, 16'h0077);
    chk_out({15'h0, coil[0]}, 16'h1);
    @(posedge clk_sys_in) din <= 2'b00;
    wr_reg(REG_DICFG, 32'h3008);
    cyc(8);
    #1 chk_out({14'h0, dstate}, 16'h3);
    // clock enable low must freeze the level register
    @(posedge clk_sys_in) ce <= 1'b0;
    lvl <= 16'h0055;
    cyc(4);
    #1 chk_out(lout, 16'h0099);
    @(posedge clk_sys_in) ce <= 1'b1;
    cyc(2);
    #1 chk_out(lout, 16'h0055);
    // elapsed time: one hour is 3600 ticks of 10 cycles
    do_reset;
    wr_reg(8'h04, 32'h0001_0000);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h00, 32'h5);
    wait_coil(1'b1, 37000);
    chk_reg({31'h0, (n >= 35950 && n <= 36030)}, 32'h1);
    wait_coil(1'b0, 40);
    cyc(2);
    #1 chk_reg(32'(hi), 32'd10);
    report_and_stop;
  end
endmodule
`default_nettype wire
